// ===== logic/fstc_pkg.sv
// Purpose: Constants for the frame-sync timer and frame number counter
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets are register addresses on the byte port
package fstc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFS_FSYNC_CTRL           = 8'h18;
  localparam logic [7:0] OFS_FSYNC_HIGH_PERIOD_HI = 8'h19;
  localparam logic [7:0] OFS_FSYNC_HIGH_PERIOD_LO = 8'h1A;
  localparam logic [7:0] OFS_FSYNC_LOW_PERIOD_HI  = 8'h1B;
  localparam logic [7:0] OFS_FSYNC_LOW_PERIOD_LO  = 8'h1C;
  localparam logic [7:0] OFS_FRAME_COUNT_LIMIT_HI = 8'h1D;
  localparam logic [7:0] OFS_FRAME_COUNT_LIMIT_LO = 8'h1E;
  localparam logic [7:0] OFS_FRAME_STATUS_HI      = 8'h30;
  localparam logic [7:0] OFS_FRAME_STATUS_LO      = 8'h31;
  localparam logic [7:0] OFS_FSYNC_STATUS         = 8'h32;
  localparam logic [7:0] RST_CTRL                 = 8'h00;
  localparam logic [7:0] RST_PERIOD_BYTE          = 8'h00;
  localparam logic [7:0] RST_LIMIT_HI             = 8'h00;
  localparam logic [7:0] RST_LIMIT_LO             = 8'h04;
  localparam int unsigned CTRL_GEN_ENABLE_BIT     = 0;
  localparam int unsigned CTRL_DUTY_MODE_BIT      = 1;
  localparam int unsigned CTRL_INIT_LEVEL_BIT     = 2;
  localparam logic [15:0] FRAME_FIRST             = 16'h0001;
  localparam logic [15:0] FRAME_NONE              = 16'h0000;
  typedef enum logic [1:0] {FSTC_IDLE, FSTC_HIGH, FSTC_LOW} fstc_state_e;
endpackage

// ===== logic/fstc_top.sv
// Purpose: Frame-sync generator periods and raw-mode frame number counter
// Assumes: One clock; synchronous inputs; byte register port, read data next cycle
// Notes:   All state but the two reset synchroniser flops held in one struct registered by a single process
// Summary of operation
// - The high-period count is 16 bits with its low byte in its own register.
// - The high period is programmed as cycles minus one, so zero gives one cycle high.
// - The low-period count is 16 bits split into an upper and a lower byte register.
// - The low period is programmed as cycles minus one, so zero gives one cycle low.
// - The maximum frame count is 16 bits in an upper and a following lower byte register.
// - In raw mode each generated frame start and frame end carries a 16-bit frame number.
// - A maximum frame count of zero disables numbering and the number reads zero.
// - Otherwise the number counts from 1 up to the maximum per frame, then wraps to 1.
// - After reset the limit low byte is 0x04 and the high byte zero.
// - The high-period upper byte sits in its own register just before the low byte.
// - Hi/Lo mode times each phase from its own count; equal-duty mode uses one 24-bit value.
// - The sync output starts at a programmable initial level before generation runs.
// - Periodic sync pulses are produced only while the generator enable bit is set.
`timescale 1ns/1ns
module fstc_top
  import fstc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              clk_en_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic              raw_mode_in,
  input  wire logic              frame_start_in,
  input  wire logic              frame_end_in,
  output logic [DATA_W-1:0]      reg_rdata_out,
  output logic                   frame_sync_signal_out,
  output logic [15:0]            fs_frame_number_out,
  output logic                   fs_packet_valid_out,
  output logic [15:0]            fe_frame_number_out,
  output logic                   fe_packet_valid_out
);

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  high_hi;
    logic [7:0]  high_lo;
    logic [7:0]  low_hi;
    logic [7:0]  low_lo;
    logic [7:0]  limit_hi;
    logic [7:0]  limit_lo;
    fstc_state_e state;
    logic [23:0] phase_cnt;
    logic        sync_level;
    logic [15:0] frame_num;
    logic [15:0] fs_num;
    logic        fs_valid;
    logic [15:0] fe_num;
    logic        fe_valid;
    logic [7:0]  rdata;
  } fstc_state_s;

  fstc_state_s cur_reg;
  fstc_state_s cur_next;
  logic [1:0]  rst_sync_reg;
  logic        rst_b;

  // Reset release through two flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  function automatic logic [7:0] reg_read(input fstc_state_s s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      OFS_FSYNC_CTRL:           d = s.ctrl;
      OFS_FSYNC_HIGH_PERIOD_HI: d = s.high_hi;
      OFS_FSYNC_HIGH_PERIOD_LO: d = s.high_lo;
      OFS_FSYNC_LOW_PERIOD_HI:  d = s.low_hi;
      OFS_FSYNC_LOW_PERIOD_LO:  d = s.low_lo;
      OFS_FRAME_COUNT_LIMIT_HI: d = s.limit_hi;
      OFS_FRAME_COUNT_LIMIT_LO: d = s.limit_lo;
      OFS_FRAME_STATUS_HI:      d = s.frame_num[15:8];
      OFS_FRAME_STATUS_LO:      d = s.frame_num[7:0];
      OFS_FSYNC_STATUS:         d = {6'h00, s.state != FSTC_IDLE, s.sync_level};
      default:                  d = 8'h00;
    endcase
    return d;
  endfunction

  // Phase length minus one for the phase being entered
  function automatic logic [23:0] phase_load(input fstc_state_s s, input logic high);
    logic [23:0] v;
    v = 24'h000000;
    if (s.ctrl[CTRL_DUTY_MODE_BIT]) begin
      v = {s.high_lo, s.low_hi, s.low_lo};
    end else if (high) begin
      v = {8'h00, s.high_hi, s.high_lo};
    end else begin
      v = {8'h00, s.low_hi, s.low_lo};
    end
    return v;
  endfunction

  always_comb begin
    logic [15:0] limit;
    logic        gen_en;
    limit    = 16'h0000;
    gen_en   = 1'b0;
    cur_next = cur_reg;
    limit    = {cur_reg.limit_hi, cur_reg.limit_lo};
    gen_en   = cur_reg.ctrl[CTRL_GEN_ENABLE_BIT];
    cur_next.fs_valid = 1'b0;
    cur_next.fe_valid = 1'b0;
    cur_next.rdata    = 8'h00;

    if (reg_rd_in) begin
      cur_next.rdata = reg_read(cur_reg, reg_addr_in);
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_FSYNC_CTRL:           cur_next.ctrl     = {5'h00, reg_wdata_in[2:0]};
        OFS_FSYNC_HIGH_PERIOD_HI: cur_next.high_hi  = reg_wdata_in;
        OFS_FSYNC_HIGH_PERIOD_LO: cur_next.high_lo  = reg_wdata_in;
        OFS_FSYNC_LOW_PERIOD_HI:  cur_next.low_hi   = reg_wdata_in;
        OFS_FSYNC_LOW_PERIOD_LO:  cur_next.low_lo   = reg_wdata_in;
        OFS_FRAME_COUNT_LIMIT_HI: cur_next.limit_hi = reg_wdata_in;
        OFS_FRAME_COUNT_LIMIT_LO: cur_next.limit_lo = reg_wdata_in;
        default: ;
      endcase
    end

    // Sync generator
    case (cur_reg.state)
      FSTC_IDLE: begin
        cur_next.sync_level = cur_reg.ctrl[CTRL_INIT_LEVEL_BIT];
        if (gen_en) begin
          cur_next.state     = cur_reg.ctrl[CTRL_INIT_LEVEL_BIT] ? FSTC_HIGH : FSTC_LOW;
          cur_next.phase_cnt = phase_load(cur_reg, cur_reg.ctrl[CTRL_INIT_LEVEL_BIT]);
        end
      end
      FSTC_HIGH: begin
        if (!gen_en) begin
          cur_next.state = FSTC_IDLE;
        end else if (cur_reg.phase_cnt == 24'h000000) begin
          cur_next.state      = FSTC_LOW;
          cur_next.sync_level = 1'b0;
          cur_next.phase_cnt  = phase_load(cur_reg, 1'b0);
        end else begin
          cur_next.phase_cnt = cur_reg.phase_cnt - 24'h000001;
        end
      end
      FSTC_LOW: begin
        if (!gen_en) begin
          cur_next.state = FSTC_IDLE;
        end else if (cur_reg.phase_cnt == 24'h000000) begin
          cur_next.state      = FSTC_HIGH;
          cur_next.sync_level = 1'b1;
          cur_next.phase_cnt  = phase_load(cur_reg, 1'b1);
        end else begin
          cur_next.phase_cnt = cur_reg.phase_cnt - 24'h000001;
        end
      end
      default: begin
        cur_next.state = FSTC_IDLE;
      end
    endcase
    if (cur_next.state != FSTC_IDLE && cur_reg.state == FSTC_IDLE) begin
      cur_next.sync_level = cur_reg.ctrl[CTRL_INIT_LEVEL_BIT];
    end

    // Frame numbering in raw mode
    if (raw_mode_in && frame_start_in) begin
      if (limit == FRAME_NONE) begin
        cur_next.frame_num = FRAME_NONE;
      end else if (cur_reg.frame_num >= limit || cur_reg.frame_num == FRAME_NONE) begin
        cur_next.frame_num = FRAME_FIRST;
      end else begin
        cur_next.frame_num = cur_reg.frame_num + 16'h0001;
      end
      cur_next.fs_num   = cur_next.frame_num;
      cur_next.fs_valid = 1'b1;
    end
    if (raw_mode_in && frame_end_in) begin
      cur_next.fe_num   = (limit == FRAME_NONE) ? FRAME_NONE : cur_next.frame_num;
      cur_next.fe_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg            <= '0;
      cur_reg.ctrl       <= RST_CTRL;
      cur_reg.high_hi    <= RST_PERIOD_BYTE;
      cur_reg.high_lo    <= RST_PERIOD_BYTE;
      cur_reg.low_hi     <= RST_PERIOD_BYTE;
      cur_reg.low_lo     <= RST_PERIOD_BYTE;
      cur_reg.limit_hi   <= RST_LIMIT_HI;
      cur_reg.limit_lo   <= RST_LIMIT_LO;
      cur_reg.state      <= FSTC_IDLE;
      cur_reg.frame_num  <= FRAME_NONE;
    end else if (clk_en_in) begin
      cur_reg <= cur_next;
    end
  end

  assign reg_rdata_out         = cur_reg.rdata;
  assign frame_sync_signal_out = cur_reg.sync_level;
  assign fs_frame_number_out   = cur_reg.fs_num;
  assign fs_packet_valid_out   = cur_reg.fs_valid;
  assign fe_frame_number_out   = cur_reg.fe_num;
  assign fe_packet_valid_out   = cur_reg.fe_valid;

endmodule

// ===== sim/fstc_assertions.sv
// Purpose: Port-level checks on fstc_top
// Assumes: One clock domain, reset on rst_b_in
// Notes:   Bound to the top module at the foot
`timescale 1ns/1ns
module fstc_checker
  import fstc_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rst_b_in,
  input wire logic              clk_en_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic              raw_mode_in,
  input wire logic              frame_start_in,
  input wire logic              frame_end_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              frame_sync_signal_out,
  input wire logic [15:0]       fs_frame_number_out,
  input wire logic              fs_packet_valid_out,
  input wire logic [15:0]       fe_frame_number_out,
  input wire logic              fe_packet_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire fs_ev = clk_en_in && raw_mode_in && frame_start_in;
  wire fe_ev = clk_en_in && raw_mode_in && frame_end_in;
  sequence wr_lo_s; clk_en_in && reg_wr_in && reg_addr_in == OFS_FSYNC_LOW_PERIOD_LO; endsequence
  sequence rd_lo_s; clk_en_in && reg_rd_in && reg_addr_in == OFS_FSYNC_LOW_PERIOD_LO; endsequence
  rd_idle_a: assert property (clk_en_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  read_back_a: assert property (wr_lo_s ##1 rd_lo_s |=>
    reg_rdata_out == $past(reg_wdata_in, 2)) else $error("low period byte read back wrong");
  fs_valid_a: assert property (fs_ev |=> fs_packet_valid_out)
    else $error("start packet missing");
  fs_quiet_a: assert property (clk_en_in && !fs_ev |=> !fs_packet_valid_out)
    else $error("start packet without event");
  fe_valid_a: assert property (fe_ev |=> fe_packet_valid_out)
    else $error("end packet missing");
  fe_quiet_a: assert property (clk_en_in && !fe_ev |=> !fe_packet_valid_out)
    else $error("end packet without event");
  fe_match_a: assert property (fe_packet_valid_out |->
    fe_frame_number_out == fs_frame_number_out)
    else $error("end number differs from start number");
  fs_hold_a: assert property (clk_en_in && !fs_ev |=> $stable(fs_frame_number_out))
    else $error("frame number moved without a start");
  fs_step_a: assert property (fs_packet_valid_out |-> fs_frame_number_out <= 16'h0001 ||
    fs_frame_number_out == $past(fs_frame_number_out) + 16'h0001) else $error("frame number step");
endmodule
bind fstc_top fstc_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .raw_mode_in(raw_mode_in), .frame_start_in(frame_start_in),
  .frame_end_in(frame_end_in), .reg_rdata_out(reg_rdata_out),
  .frame_sync_signal_out(frame_sync_signal_out), .fs_frame_number_out(fs_frame_number_out),
  .fs_packet_valid_out(fs_packet_valid_out), .fe_frame_number_out(fe_frame_number_out),
  .fe_packet_valid_out(fe_packet_valid_out));

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for fstc_top
// Assumes: 250 MHz clock, bench drives every port
// Notes:   clk_en_in dropped once to check a frozen frame start
`timescale 1ns/1ns
module tb_top
  import fstc_pkg::*;
;
  logic        clk_in = 0, rst_b_in = 0, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic        raw_mode_in = 1, frame_start_in = 0, frame_end_in = 0, sync_o, fs_v, fe_v;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [15:0] fs_n, fe_n;
  int          err_total = 0, checks = 0, cyc = 0, i;
  fstc_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .raw_mode_in(raw_mode_in), .frame_start_in(frame_start_in),
    .frame_end_in(frame_end_in), .reg_rdata_out(reg_rdata_out), .frame_sync_signal_out(sync_o),
    .fs_frame_number_out(fs_n), .fs_packet_valid_out(fs_v), .fe_frame_number_out(fe_n),
    .fe_packet_valid_out(fe_v));
  initial forever #2 clk_in = ~clk_in;
  task chk(input logic [15:0] e, g, input string n);
    checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task close_out;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task rd(input logic [7:0] a, e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(16'(e), 16'(reg_rdata_out), "read data");
    @(posedge clk_in);
  endtask
  task frm(input logic s, e, input logic [15:0] n);
    frame_start_in <= s;
    frame_end_in <= e;
    @(posedge clk_in);
    frame_start_in <= 1'b0;
    frame_end_in <= 1'b0;
    #1 chk(16'(s & raw_mode_in), 16'(fs_v), "start valid");
    chk(16'(e & raw_mode_in), 16'(fe_v), "end valid");
    chk(n, fs_n, "start number");
    if (e) chk(n, fe_n, "end number");
    @(posedge clk_in);
  endtask
  task sync_run(input int h, l);
    int n;
    #1 n = 0;
    while (sync_o !== 1'b0 && n < 99) @(posedge clk_in) #1 n++;
    while (sync_o !== 1'b1 && n < 99) @(posedge clk_in) #1 n++;
    for (n = 0; sync_o === 1'b1 && n < 99; n++) @(posedge clk_in) #1;
    chk(16'(h), 16'(n), "high run");
    for (n = 0; sync_o === 1'b0 && n < 99; n++) @(posedge clk_in) #1;
    chk(16'(l), 16'(n), "low run");
    @(posedge clk_in);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (i = 0; i < 7; i++) rd(8'h18 + 8'(i), (i == 6) ? RST_LIMIT_LO : 8'h00);
    for (i = 1; i < 7; i++) frm(1'b1, 1'b0, 16'((i - 1) % 4 + 1));
    frm(1'b0, 1'b1, 16'h0002);
    rd(OFS_FRAME_STATUS_HI, 8'h00);
    rd(OFS_FRAME_STATUS_LO, 8'h02);
    raw_mode_in <= 1'b0;
    frm(1'b1, 1'b1, 16'h0002);
    raw_mode_in <= 1'b1;
    for (i = 1; i < 7; i++) begin
      reg_addr_in <= 8'h18 + 8'(i);
      reg_wdata_in <= 8'hC0 + 8'(i);
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      rd(8'h18 + 8'(i), 8'hC0 + 8'(i));
    end
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(OFS_FRAME_COUNT_LIMIT_HI, 8'h00);
    wr(OFS_FRAME_COUNT_LIMIT_LO, 8'h00);
    frm(1'b1, 1'b1, 16'h0000);
    wr(OFS_FRAME_COUNT_LIMIT_HI, 8'h01);
    wr(OFS_FRAME_COUNT_LIMIT_LO, 8'h02);
    for (i = 0; i < 259; i++) frm(1'b1, 1'b1, 16'(i % 258 + 1));
    for (i = 1; i < 5; i++) wr(8'h18 + 8'(i), (i == 4) ? 8'h01 : 8'h00);
    wr(OFS_FSYNC_CTRL, 8'h01);
    sync_run(1, 2);
    wr(OFS_FSYNC_HIGH_PERIOD_LO, 8'h02);
    sync_run(3, 2);
    wr(OFS_FSYNC_HIGH_PERIOD_LO, 8'h00);
    wr(OFS_FSYNC_LOW_PERIOD_LO, 8'h02);
    wr(OFS_FSYNC_CTRL, 8'h03);
    sync_run(3, 3);
    wr(OFS_FSYNC_CTRL, 8'h04);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_in);
      #1 chk(16'h0001, 16'(sync_o), "idle level");
    end
    @(posedge clk_in);
    rd(OFS_FSYNC_CTRL, 8'h04);
    rd(OFS_FSYNC_STATUS, 8'h01);
    // Start pulse during a frozen edge must be lost
    clk_en_in <= 1'b0;
    frame_start_in <= 1'b1;
    @(posedge clk_in);
    clk_en_in <= 1'b1;
    frame_start_in <= 1'b0;
    #1 chk(16'h0000, 16'(fs_v), "frozen start valid");
    @(posedge clk_in);
    frm(1'b1, 1'b1, 16'h0002);
    close_out;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out;
    end
  end
endmodule
